// ==== pkg/asrm_pkg.sv ====
// asrm_pkg: constants shared by the converter readout control block
// assumes a 125 MHz system clock; the analog core and the host live outside
package asrm_pkg;

  // system clock
  localparam int unsigned CLK_PERIOD_NS = 8;

  // conversion time given in ns, cycle count rounded up
  localparam int unsigned CONV_TIME_NS = 4000;
  localparam int unsigned CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONV_CNT_W = 10;

  // result word
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BIT_CNT_W = 5;

  // internal shift clock: one bit spans five system cycles
  // clock decoded high in phases 1..2, registered so the pin is high in 2..3;
  // data only moves at phase 4 -> 0, one cycle after the falling edge
  localparam logic [2:0] PH_LAST = 3'h4;
  localparam logic [2:0] PH_HIGH_FIRST = 3'h1;
  localparam logic [2:0] PH_HIGH_LAST = 3'h2;

  // channel address
  localparam int unsigned CHAN_W = 2;
  localparam int unsigned CHAN_N = 4;

  // reset values
  localparam logic [WORD_W-1:0] RESULT_RST = 16'h0000;
  localparam logic [CHAN_W-1:0] CHAN_RST = 2'h0;

  // conversion control states
  typedef enum logic [0:0]
  {
    ASRM_IDLE = 1'b0,
    ASRM_CONV = 1'b1
  } asrm_state_e;

endpackage

// ==== src/asrm_ctrl.sv ====
// asrm_ctrl: strobe decode, busy, channel latch and serial result readout
// assumes all control pins arrive asynchronously to clk; in external clock
// mode serial_shift_clock clocks the readout logic and may stop between frames
`timescale 1ns/1ps

// What this block does
// - clock pin drives out only when clock source select low
// - internal mode sends sixteen clocks per conversion
// - internal data stable on both clock edges
// - result shifted out MSB first from register
// - external read of previous or current result
// - strobe levels pick conversion or readout
// - latch enable is OR of write strobes
// - both strobes low makes latch transparent
// - select fall with strobe low starts conversion
// - select fall with strobe high starts readout in external clock mode
// - busy drops when conversion starts
// - busy rises in the same cycle the result loads
// - address captured by combined write strobes
// - latched code picks one of four inputs
// - strobe fall converts, strobe rise reads in external clock mode
// - external read emits one-period frame pulse
// - power-down blocks new conversions; a running one still loads its result
// - internal clock rests low after last bit
module asrm_ctrl
(
  // clocks and reset
  input wire logic clk,
  input wire logic reset,
  // host strobes
  input wire logic chip_select_n,
  input wire logic read_convert,
  input wire logic clock_source_select,
  input wire logic power_down_in,
  // channel address and latch strobes
  input wire logic mux_latch_strobe_a_n,
  input wire logic mux_latch_strobe_b_n,
  input wire logic channel_addr_hi,
  input wire logic channel_addr_lo,
  // serial shift clock pin, split into input, output, enable
  input wire logic serial_shift_clock,
  output logic serial_shift_clock_out,
  output logic serial_shift_clock_oe,
  // serial result and frame pulse
  output logic serial_data,
  output logic frame_sync,
  output logic busy_n,
  // analog core side
  input wire logic [asrm_pkg::WORD_W-1:0] conv_result,
  output logic sample_hold,
  output logic [asrm_pkg::CHAN_W-1:0] channel_sel,
  output logic [asrm_pkg::CHAN_N-1:0] channel_onehot
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int unsigned NPIN = 8;

  // three-stage sampler per pin
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_q;
  logic [NPIN-1:0] pin_s2_q;
  logic [NPIN-1:0] pin_s3_q;
  logic [NPIN-1:0] pin_f_q;
  logic [NPIN-1:0] pin_f_d;

  // pin order within the sampled vector
  assign pin_raw = {channel_addr_hi, channel_addr_lo, mux_latch_strobe_b_n, mux_latch_strobe_a_n,
                    power_down_in, clock_source_select, read_convert, chip_select_n};

  // filtered value moves only once stages two and three agree
  assign pin_f_d = (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q | pin_s3_q));

  // sampler chain, idle levels: strobes high, others low
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pin_s1_q <= 8'h33;
      pin_s2_q <= 8'h33;
      pin_s3_q <= 8'h33;
      pin_f_q <= 8'h33;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q <= pin_f_d;
    end
  end

  // named filtered pins
  wire cs_n_f = pin_f_q[0];
  wire rc_f = pin_f_q[1];
  wire ext_mode_f = pin_f_q[2];
  wire pd_f = pin_f_q[3];
  wire wr_a_n_f = pin_f_q[4];
  wire wr_b_n_f = pin_f_q[5];
  wire [1:0] addr_f = pin_f_q[7:6];

  // previous filtered levels for edge detection
  logic cs_n_prev_q;
  logic rc_prev_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cs_n_prev_q <= 1'b1;
      rc_prev_q <= 1'b1;
    end
    else
    begin
      cs_n_prev_q <= cs_n_f;
      rc_prev_q <= rc_f;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobe decode

  // edges of the two strobes
  wire cs_fall = cs_n_prev_q & ~cs_n_f;
  wire rc_fall = rc_prev_q & ~rc_f;
  wire rc_rise = ~rc_prev_q & rc_f;

  // conversion and read requests from strobe levels
  wire conv_req = (cs_fall & ~rc_f) | (rc_fall & ~cs_n_f);
  wire read_req = (cs_fall & rc_f) | (rc_rise & ~cs_n_f);

  ////////////////////////////////////////////////////////////////////////////
  // channel address latch

  // latch open while the ORed strobes sit low
  wire latch_en = ~(wr_a_n_f | wr_b_n_f);

  // one-hot input select from the two-bit code
  function automatic logic [asrm_pkg::CHAN_N-1:0] chan_decode(input logic [asrm_pkg::CHAN_W-1:0] code);
    chan_decode = 4'h1 << code;
  endfunction

  // captured address; follows inputs while open
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      channel_sel <= asrm_pkg::CHAN_RST;
    else if (latch_en)
      channel_sel <= addr_f;
  end

  assign channel_onehot = chan_decode(channel_sel);

  ////////////////////////////////////////////////////////////////////////////
  // conversion control

  asrm_pkg::asrm_state_e state_q;
  asrm_pkg::asrm_state_e state_d;
  logic [asrm_pkg::CONV_CNT_W-1:0] conv_cnt_q;
  logic [asrm_pkg::WORD_W-1:0] out_sr_q; // result holding register
  logic tx_active_q;

  // start accepted only idle and powered up
  wire conv_go = conv_req & (state_q == asrm_pkg::ASRM_IDLE) & ~pd_f;
  // load waits for the internal shift-out to finish
  wire conv_done = (state_q == asrm_pkg::ASRM_CONV) & (conv_cnt_q == '0) & ~tx_active_q;

  // next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      asrm_pkg::ASRM_IDLE:
      begin
        if (conv_go)
          state_d = asrm_pkg::ASRM_CONV;
      end
      asrm_pkg::ASRM_CONV:
      begin
        if (conv_done)
          state_d = asrm_pkg::ASRM_IDLE;
      end
      default:
        state_d = asrm_pkg::ASRM_IDLE;
    endcase
  end

  // state, timer, busy, result load
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= asrm_pkg::ASRM_IDLE;
      conv_cnt_q <= '0;
      busy_n <= 1'b1;
      out_sr_q <= asrm_pkg::RESULT_RST;
    end
    else
    begin
      state_q <= state_d;
      if (conv_go)
      begin
        conv_cnt_q <= asrm_pkg::CONV_CNT_W'(asrm_pkg::CONV_CYCLES - 1);
        busy_n <= 1'b0;
      end
      else if (conv_done)
      begin
        out_sr_q <= conv_result;
        busy_n <= 1'b1;
      end
      else if (conv_cnt_q != '0)
        conv_cnt_q <= conv_cnt_q - 1'b1;
    end
  end

  // hold the analog input while converting
  assign sample_hold = (state_q == asrm_pkg::ASRM_CONV);

  ////////////////////////////////////////////////////////////////////////////
  // internal clock readout

  logic [2:0] phase_q;
  logic [asrm_pkg::BIT_CNT_W-1:0] bit_cnt_q;
  logic [asrm_pkg::WORD_W-1:0] tx_sr_q;
  logic sclk_q;

  wire int_start = conv_go & ~ext_mode_f;
  wire last_bit = (bit_cnt_q == asrm_pkg::BIT_CNT_W'(asrm_pkg::WORD_W - 1));
  wire bit_end = tx_active_q & (phase_q == asrm_pkg::PH_LAST);
  wire sclk_high = tx_active_q & (phase_q >= asrm_pkg::PH_HIGH_FIRST) & (phase_q <= asrm_pkg::PH_HIGH_LAST);

  // previous result goes out during conversion
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tx_active_q <= 1'b0;
      phase_q <= '0;
      bit_cnt_q <= '0;
      tx_sr_q <= asrm_pkg::RESULT_RST;
      sclk_q <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk_high;
      if (int_start)
      begin
        tx_active_q <= 1'b1;
        phase_q <= '0;
        bit_cnt_q <= '0;
        tx_sr_q <= out_sr_q;
      end
      else if (bit_end)
      begin
        // data moves a full phase after the falling edge
        phase_q <= '0;
        tx_sr_q <= {tx_sr_q[asrm_pkg::WORD_W-2:0], 1'b0};
        bit_cnt_q <= bit_cnt_q + 1'b1;
        if (last_bit)
          tx_active_q <= 1'b0;
      end
      else if (tx_active_q)
        phase_q <= phase_q + 1'b1;
    end
  end

  // pin drives out only in internal mode
  assign serial_shift_clock_oe = ~ext_mode_f;
  assign serial_shift_clock_out = sclk_q;

  ////////////////////////////////////////////////////////////////////////////
  // external clock readout

  // read request crosses as a toggle; the word is held in out_sr_q
  logic read_tgl_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      read_tgl_q <= 1'b0;
    else if (read_req & ext_mode_f)
      read_tgl_q <= ~read_tgl_q;
  end

  logic lk_s1_q;
  logic lk_s2_q;
  logic lk_s3_q;
  logic lk_f_q;
  logic lk_prev_q;
  logic [asrm_pkg::BIT_CNT_W-1:0] lk_cnt_q;
  logic [asrm_pkg::WORD_W-1:0] lk_sr_q;

  wire lk_f_d = (lk_s2_q & lk_s3_q) | (lk_f_q & (lk_s2_q | lk_s3_q));
  wire lk_start = lk_f_q ^ lk_prev_q;

  // link side: frame pulse and shift, rising edges of host clock
  always_ff @(posedge serial_shift_clock or posedge reset)
  begin
    if (reset)
    begin
      lk_s1_q <= 1'b0;
      lk_s2_q <= 1'b0;
      lk_s3_q <= 1'b0;
      lk_f_q <= 1'b0;
      lk_prev_q <= 1'b0;
      lk_cnt_q <= '0;
      lk_sr_q <= asrm_pkg::RESULT_RST;
      frame_sync <= 1'b0;
    end
    else
    begin
      lk_s1_q <= read_tgl_q;
      lk_s2_q <= lk_s1_q;
      lk_s3_q <= lk_s2_q;
      lk_f_q <= lk_f_d;
      lk_prev_q <= lk_f_q;
      frame_sync <= lk_start;
      if (lk_start)
      begin
        lk_sr_q <= out_sr_q;
        lk_cnt_q <= asrm_pkg::BIT_CNT_W'(asrm_pkg::WORD_W - 1);
      end
      else if (lk_cnt_q != '0)
      begin
        lk_sr_q <= {lk_sr_q[asrm_pkg::WORD_W-2:0], 1'b0};
        lk_cnt_q <= lk_cnt_q - 1'b1;
      end
    end
  end

  // data pin source follows the clock mode
  assign serial_data = ext_mode_f ? lk_sr_q[asrm_pkg::WORD_W-1] : tx_sr_q[asrm_pkg::WORD_W-1];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // rising clock edges seen in one internal frame
  logic [asrm_pkg::BIT_CNT_W:0] edge_cnt_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      edge_cnt_q <= '0;
    else if (int_start)
      edge_cnt_q <= '0;
    else if (sclk_high & ~sclk_q)
      edge_cnt_q <= edge_cnt_q + 1'b1;
  end

  pin_dir_a: assert property (@(posedge clk) disable iff (reset)
    serial_shift_clock_oe == ~ext_mode_f) else $error("clock pin direction wrong");
  pulse_count_a: assert property (@(posedge clk) disable iff (reset)
    $fell(tx_active_q) |-> edge_cnt_q == 6'h10) else $error("internal frame not sixteen clocks");
  data_stable_a: assert property (@(posedge clk) disable iff (reset)
    ($rose(sclk_q) || $fell(sclk_q)) |-> $stable(tx_sr_q)) else $error("data moved at clock edge");
  msb_load_a: assert property (@(posedge clk) disable iff (reset)
    int_start |=> tx_sr_q == $past(out_sr_q)) else $error("shift register not loaded");
  latch_pass_a: assert property (@(posedge clk) disable iff (reset)
    latch_en |=> channel_sel == $past(addr_f)) else $error("latch not transparent");
  latch_hold_a: assert property (@(posedge clk) disable iff (reset)
    !latch_en |=> $stable(channel_sel)) else $error("closed latch changed");
  chan_pick_a: assert property (@(posedge clk) disable iff (reset)
    channel_onehot[channel_sel] && $onehot(channel_onehot)) else $error("channel decode wrong");
  busy_start_a: assert property (@(posedge clk) disable iff (reset)
    conv_go |=> !busy_n [*8]) else $error("busy not low after start");
  busy_end_a: assert property (@(posedge clk) disable iff (reset)
    $rose(busy_n) |-> out_sr_q == $past(conv_result) && $past(conv_cnt_q) == '0)
    else $error("busy rose without load");
  start_decode_a: assert property (@(posedge clk) disable iff (reset)
    (cs_fall && !rc_f && !pd_f && state_q == asrm_pkg::ASRM_IDLE) |=> !busy_n)
    else $error("select fall did not convert");
  pd_block_a: assert property (@(posedge clk) disable iff (reset)
    (pd_f && state_q == asrm_pkg::ASRM_IDLE) |=> state_q == asrm_pkg::ASRM_IDLE && $stable(out_sr_q))
    else $error("conversion under power-down");
  busy_ignore_a: assert property (@(posedge clk) disable iff (reset)
    (conv_req && state_q == asrm_pkg::ASRM_CONV && conv_cnt_q != '0) |=> conv_cnt_q == $past(conv_cnt_q) - 1'b1)
    else $error("restart while busy");
  clock_rest_a: assert property (@(posedge clk) disable iff (reset)
    !tx_active_q |=> !sclk_q) else $error("idle clock not low");
  frame_pulse_a: assert property (@(posedge serial_shift_clock) disable iff (reset)
    lk_start |=> frame_sync ##1 !frame_sync) else $error("frame pulse width wrong");

  conv_cov: cover property (@(posedge clk) disable iff (reset) $rose(busy_n));
  int_frame_cov: cover property (@(posedge clk) disable iff (reset) $fell(tx_active_q));
  ext_read_cov: cover property (@(posedge serial_shift_clock) disable iff (reset) frame_sync);

endmodule

// ==== verif/asrm_host_model.sv ====
// asrm_host_model: host controller driving strobes, address and link clock
// assumes the bench resolves the shared clock pin from the device enable
`timescale 1ns/1ps
module asrm_host_model
(
  // system clock, used only to time strobe, address and mode pin changes
  input wire logic clk,
  // strobes and mode pins
  output logic chip_select_n,
  output logic read_convert,
  output logic clock_source_select,
  output logic power_down_in,
  // channel latch
  output logic mux_latch_strobe_a_n,
  output logic mux_latch_strobe_b_n,
  output logic channel_addr_hi,
  output logic channel_addr_lo,
  // link side
  output logic host_clk,
  input wire logic serial_data,
  input wire logic frame_sync
);
  ////////////////////////////////////////////////////////////////////////
  // idle levels from time zero; link clock stands low outside frames
  initial
  begin
    chip_select_n = 1'b1;
    read_convert = 1'b1;
    clock_source_select = 1'b0;
    power_down_in = 1'b0;
    mux_latch_strobe_a_n = 1'b1;
    mux_latch_strobe_b_n = 1'b1;
    {channel_addr_hi, channel_addr_lo} = 2'h0;
    host_clk = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // strobe low wide enough for the input filter, then back high
  task automatic convert();
    @(posedge clk);
    read_convert <= 1'b0;
    repeat (8) @(posedge clk);
    read_convert <= 1'b1;
  endtask
  // select high, then falling while the strobe is high asks for a read
  task automatic select_read();
    @(posedge clk);
    chip_select_n <= 1'b1;
    repeat (8) @(posedge clk);
    chip_select_n <= 1'b0;
  endtask
  // strobe low first, then select falling starts a conversion
  task automatic select_convert();
    @(posedge clk);
    chip_select_n <= 1'b1;
    read_convert <= 1'b0;
    repeat (8) @(posedge clk);
    chip_select_n <= 1'b0;
    repeat (8) @(posedge clk);
    read_convert <= 1'b1;
  endtask
  // address and both latch strobes in one edge
  task automatic latch(input logic [1:0] code, input logic a_n, input logic b_n);
    @(posedge clk);
    {channel_addr_hi, channel_addr_lo} <= code;
    mux_latch_strobe_a_n <= a_n;
    mux_latch_strobe_b_n <= b_n;
  endtask
  // clock source and power-down levels
  task automatic set_mode(input logic ext, input logic pd);
    @(posedge clk);
    clock_source_select <= ext;
    power_down_in <= pd;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // one frame at an 80 ns clock period; bits taken late in the high half, from the pulse on
  task automatic clock_read(output logic [asrm_pkg::WORD_W-1:0] word, output int pulses);
    int n;
    n = -1;
    pulses = 0;
    word = '0;
    #3;
    for (int i = 0; i < 40 && n < 16; i++)
    begin
      host_clk = 1'b1;
      #38;
      if (frame_sync === 1'b1)
        pulses++;
      if (frame_sync === 1'b1 && n < 0)
        n = 0;
      if (n >= 0)
      begin
        word[15-n] = serial_data;
        n++;
      end
      #2;
      host_clk = 1'b0;
      #40;
    end
  endtask
endmodule

// ==== verif/adc_serial_readout_mux_ctrl_test.sv ====
// adc_serial_readout_mux_ctrl_test: self-checking bench for asrm_ctrl
// assumes asrm_host_model stands in for the host controller
`timescale 1ns/1ps
module adc_serial_readout_mux_ctrl_test;
  logic clk;
  logic reset;
  logic [asrm_pkg::WORD_W-1:0] conv_result;
  wire cs_n, rc, sel, pd, wa_n, wb_n, a_hi, a_lo, host_clk, sclk_pin;
  wire sclk_out, sclk_oe, sdata, fsync, busy_n, sample_hold;
  wire [asrm_pkg::CHAN_W-1:0] channel_sel;
  wire [asrm_pkg::CHAN_N-1:0] onehot;
  int miscompares;
  int checks;
  // shared clock pin: device drives it while enabled
  assign sclk_pin = sclk_oe ? sclk_out : host_clk;
  asrm_ctrl uut (.clk(clk), .reset(reset), .chip_select_n(cs_n), .read_convert(rc),
    .clock_source_select(sel), .power_down_in(pd), .mux_latch_strobe_a_n(wa_n),
    .mux_latch_strobe_b_n(wb_n), .channel_addr_hi(a_hi), .channel_addr_lo(a_lo),
    .serial_shift_clock(sclk_pin), .serial_shift_clock_out(sclk_out), .serial_shift_clock_oe(sclk_oe),
    .serial_data(sdata), .frame_sync(fsync), .busy_n(busy_n), .conv_result(conv_result),
    .sample_hold(sample_hold), .channel_sel(channel_sel), .channel_onehot(onehot));
  asrm_host_model host (.clk(clk), .chip_select_n(cs_n), .read_convert(rc), .clock_source_select(sel),
    .power_down_in(pd), .mux_latch_strobe_a_n(wa_n), .mux_latch_strobe_b_n(wb_n),
    .channel_addr_hi(a_hi), .channel_addr_lo(a_lo), .host_clk(host_clk),
    .serial_data(sdata), .frame_sync(fsync));
  ////////////////////////////////////////////////////////////////////////
  // 125 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // compare and count
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // bounded wait for a busy level
  task automatic wait_busy(input logic lvl, input int lim);
    for (int n = 0; n < lim && busy_n !== lvl; n++)
      @(negedge clk);
    check("busy level", busy_n, lvl);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // four codes through an open latch, then held while either strobe is high
  task automatic test_latch();
    for (int c = 0; c < 4; c++)
    begin
      host.latch(2'(c), 1'b0, 1'b0);
      repeat (8) @(posedge clk);
      check("channel_sel", 16'(channel_sel), 16'(c));
      check("channel_onehot", 16'(onehot), 16'(1 << c));
    end
    host.latch(2'h3, 1'b1, 1'b0);
    host.latch(2'h0, 1'b1, 1'b0);
    repeat (8) @(posedge clk);
    host.latch(2'h0, 1'b0, 1'b1);
    repeat (8) @(posedge clk);
    check("latch closed", 16'(channel_sel), 16'h3);
  endtask
  // internal conversion with a refused start while busy
  task automatic test_internal(input logic [15:0] prev, input logic [15:0] next);
    int low_cnt;
    int rises;
    logic [15:0] word;
    logic last_clk;
    logic bit_hi;
    logic rest;
    low_cnt = 0;
    rises = 0;
    word = '0;
    last_clk = 1'b0;
    bit_hi = 1'b0;
    rest = 1'b0;
    @(posedge clk);
    conv_result <= next;
    fork
      host.convert();
      begin
        repeat (150) @(posedge clk);
        host.convert();
      end
      begin
        wait_busy(1'b0, 20);
        while (busy_n === 1'b0 && low_cnt < 700)
        begin
          if (low_cnt == 250)
            check("sample_hold", 16'(sample_hold), 16'h1);
          if (sclk_out === 1'b1 && last_clk === 1'b0)
          begin
            rises++;
            word = {word[14:0], sdata};
            bit_hi = sdata;
          end
          if (sclk_out === 1'b1 && last_clk === 1'b1)
            check("data while high", 16'(sdata), 16'(bit_hi));
          last_clk = sclk_out;
          low_cnt++;
          @(negedge clk);
        end
      end
    join
    check("shifted word", word, prev);
    check("clock periods", 16'(rises), 16'd16);
    check("busy span", 16'(low_cnt >= asrm_pkg::CONV_CYCLES && low_cnt <= asrm_pkg::CONV_CYCLES + 2), 16'h1);
    repeat (20) @(negedge clk) rest |= sclk_out;
    check("clock rests low", 16'(rest), 16'h0);
  endtask
  // start refused while powered down
  task automatic test_power_down(input logic [15:0] value);
    logic seen_low;
    seen_low = 1'b0;
    host.set_mode(1'b0, 1'b1);
    @(posedge clk);
    conv_result <= value;
    host.convert();
    repeat (40) @(negedge clk) seen_low |= ~busy_n;
    check("power-down start", 16'(seen_low), 16'h0);
    host.set_mode(1'b0, 1'b0);
    repeat (10) @(posedge clk);
  endtask
  // external clock: read after, then during a conversion, then after again
  task automatic test_external(input logic [15:0] cur, input logic [15:0] next);
    logic [15:0] word;
    int pulses;
    host.set_mode(1'b1, 1'b0);
    repeat (10) @(posedge clk);
    check("clock pin enable", 16'(sclk_oe), 16'h0);
    host.select_read();
    host.clock_read(word, pulses);
    check("read after", word, cur);
    check("frame pulses", 16'(pulses), 16'h1);
    @(posedge clk);
    conv_result <= next;
    host.convert();
    host.clock_read(word, pulses);
    check("read during", word, cur);
    check("busy in read", 16'(busy_n), 16'h0);
    wait_busy(1'b1, 700);
    host.select_read();
    host.clock_read(word, pulses);
    check("read new", word, next);
  endtask
  // select falling while the strobe is low converts; strobe rise then reads
  task automatic test_select_start(input logic [15:0] value);
    logic [15:0] word;
    int pulses;
    @(posedge clk);
    conv_result <= value;
    host.select_convert();
    wait_busy(1'b0, 20);
    wait_busy(1'b1, 700);
    host.clock_read(word, pulses);
    check("select start word", word, value);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    miscompares = 0;
    checks = 0;
    reset = 1'b1;
    conv_result = '0;
    repeat (3) @(posedge clk);
    check("reset busy_n", 16'(busy_n), 16'h1);
    check("reset enable", 16'(sclk_oe), 16'h1);
    reset <= 1'b0;
    host.select_read();
    test_latch();
    test_internal(asrm_pkg::RESULT_RST, 16'ha5c3);
    test_power_down(16'h1234);
    test_internal(16'ha5c3, 16'h8001);
    test_external(16'h8001, 16'h7e18);
    test_select_start(16'h3c96);
    summarize();
  end
  // watchdog well past the expected run length
  initial
  begin
    #200000;
    miscompares++;
    summarize();
  end
endmodule
